// ---- core/port_ctrl_pkg.sv ----
// Shared constants for the per-port master mode and per-channel register bank.
// Assumes a 50 MHz core clock and one 8-bit register per aligned 32-bit bus word.
package port_ctrl_pkg;

    // Bus geometry
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 8;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_MASTER_MODE = 8'h00;
    localparam logic [7:0] IDX_FUNC_PTR = 8'h28;
    localparam logic [7:0] IDX_CHMAP_LOW = 8'h29;
    localparam logic [7:0] IDX_CHMAP_SECOND = 8'h2a;
    localparam logic [7:0] IDX_CHMAP_THIRD = 8'h2b;
    localparam logic [7:0] IDX_CHMAP_HIGH = 8'h2c;
    localparam logic [7:0] IDX_LINE_IF_CTRL2 = 8'h3e;
    localparam logic [7:0] IDX_BLOCK_STATUS = 8'h3f;

    // Master mode field positions
    localparam int MM_SOFT_RESET_BIT = 0;
    localparam int MM_STANDARD_BIT = 1;
    localparam int MM_TEST_LO_BIT = 2;
    localparam int MM_TEST_HI_BIT = 3;
    // Line interface control two: reset request bit
    localparam int LINE_IF_CONTROL_TWO_LINE_IF_RESET_BIT = 6;
    // Function pointer bits named in this block
    localparam int PTR_TX_HW_SIG = 3;
    localparam int PTR_BERT_RX = 4;
    localparam int PTR_RX_FRACTIONAL = 5;
    localparam int PTR_RX_SIG_REINSERT = 6;
    localparam int PTR_RX_SIG_ALL_ONES = 7;
    // Block status field positions
    localparam int ST_CLEARING_BIT = 0;
    localparam int ST_LINE_IF_BUSY_BIT = 1;
    localparam int ST_TRAFFIC_BIT = 2;

    // Reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Per-channel map geometry: eight functions, four bytes of channels each
    localparam int NUM_FUNC = 8;
    localparam int NUM_MAP_BYTES = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_FREQ_KHZ = 50_000;
    localparam int LI_RECOVER_TIME_MS = 40;
    localparam int LI_RECOVER_CYCLES = LI_RECOVER_TIME_MS * CLK_FREQ_KHZ;
    localparam int CLEAR_CYCLES = 8;

    typedef enum logic [1:0] {
        PIN_NORMAL = 2'b00,
        PIN_TRISTATE = 2'b01,
        PIN_DRIVE_LOW = 2'b10,
        PIN_DRIVE_HIGH = 2'b11
    } pin_test_t;

    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_CLEAR = 1'b1
    } seq_state_t;

    // True when exactly one bit is set
    function automatic logic is_one_hot(input logic [7:0] v);
        return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction

    // True when an index names a register of this bank
    function automatic logic reg_mapped(input logic [7:0] idx);
        return (idx == IDX_MASTER_MODE) || (idx == IDX_FUNC_PTR) ||
               ((idx >= IDX_CHMAP_LOW) && (idx <= IDX_CHMAP_HIGH)) ||
               (idx == IDX_LINE_IF_CTRL2) || (idx == IDX_BLOCK_STATUS);
    endfunction

endpackage

// ---- core/chan_map_if.sv ----
// Carrier between the register bank and the per-channel map store.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface chan_map_if #(
    parameter int NUM_FUNC = 8,
    parameter int NUM_BYTES = 4
);
    logic clear;
    logic wr_en;
    logic [NUM_FUNC-1:0] func_sel;
    logic [$clog2(NUM_BYTES)-1:0] wr_byte;
    logic [7:0] wr_data;
    logic [$clog2(NUM_BYTES)-1:0] rd_byte;
    logic [7:0] rd_data;
    logic [NUM_FUNC*NUM_BYTES*8-1:0] map_flat;

    modport owner(output clear, wr_en, func_sel, wr_byte, wr_data, rd_byte, input rd_data, map_flat);
    modport store(input clear, wr_en, func_sel, wr_byte, wr_data, rd_byte, output rd_data, map_flat);
endinterface

// ---- core/chan_map_store.sv ----
// Per-function channel maps: one bit per channel, eight functions.
// Assumes the owner gives a one-hot function select on reads.
`timescale 1ns/100ps
module chan_map_store #(
    parameter int NUM_FUNC = 8,
    parameter int NUM_BYTES = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    chan_map_if.store bus
);
    import port_ctrl_pkg::*;

    logic [7:0] map_mem [NUM_FUNC][NUM_BYTES];
    logic [$clog2(NUM_FUNC)-1:0] rd_func;

    // A write lands in every selected function at once
    always_ff @(posedge core_clk) begin
        for (int f = 0; f < NUM_FUNC; f++) begin
            for (int b = 0; b < NUM_BYTES; b++) begin
                if (reset || bus.clear) begin
                    map_mem[f][b] <= REG_RST;
                end else if (bus.wr_en && bus.func_sel[f] && (bus.wr_byte == b)) begin
                    map_mem[f][b] <= bus.wr_data;
                end
            end
        end
    end

    // Readback is defined only for a single selected function
    always_comb begin
        rd_func = '0;
        for (int f = 0; f < NUM_FUNC; f++) begin
            if (bus.func_sel[f]) begin
                rd_func = f[$clog2(NUM_FUNC)-1:0];
            end
        end
    end
    assign bus.rd_data = is_one_hot(bus.func_sel) ? map_mem[rd_func][bus.rd_byte] : REG_RST;

    // Bit 0 of byte 0 is the lowest channel
    for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
        for (genvar b = 0; b < NUM_BYTES; b++) begin : g_byte
            assign bus.map_flat[(f*NUM_BYTES+b)*8 +: 8] = map_mem[f][b];
        end
    end
endmodule

// ---- core/reset_seq.sv ----
// Chip clear sequencer: power-up, reset pin and software request each start it.
// Assumes the pin is synchronous to the core clock.
`timescale 1ns/100ps
module reset_seq #(
    parameter int CLEAR_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hw_reset_pin,
    input wire logic soft_req,
    output logic clearing
);
    import port_ctrl_pkg::*;

    localparam int CNT_W = $clog2(CLEAR_CYCLES + 1);
    seq_state_t state_r;
    logic [CNT_W-1:0] cnt_r;
    wire start = hw_reset_pin || soft_req;
    wire last = (cnt_r == CNT_W'(CLEAR_CYCLES - 1));

    // Power-up enters the clear state so no host action is needed
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= SEQ_CLEAR;
            cnt_r <= '0;
        end else if (start) begin
            state_r <= SEQ_CLEAR;
            cnt_r <= '0;
        end else begin
            case (state_r)
                SEQ_CLEAR: begin
                    cnt_r <= cnt_r + CNT_W'(1);
                    if (last) begin
                        state_r <= SEQ_IDLE;
                    end
                end
                SEQ_IDLE: cnt_r <= '0;
                default: state_r <= SEQ_IDLE;
            endcase
        end
    end

    // Registered view of the clear window
    always_ff @(posedge core_clk) begin
        if (reset) begin
            clearing <= 1'b1;
        end else begin
            clearing <= start || ((state_r == SEQ_CLEAR) && !last);
        end
    end
endmodule

// ---- core/port_ctrl_regs.sv ----
// Master mode and per-channel register bank of one transceiver port, on AXI4-Lite.
// Assumes a single 50 MHz core clock and a bus master that keeps AXI4-Lite rules.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module port_ctrl_regs
    import port_ctrl_pkg::*;
#(
    parameter int LI_RECOVER_CYCLES = port_ctrl_pkg::LI_RECOVER_CYCLES,
    parameter int CLEAR_CYCLES = port_ctrl_pkg::CLEAR_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hw_reset_pin,
    input wire logic [port_ctrl_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [port_ctrl_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [port_ctrl_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [port_ctrl_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic framer_e1_mode,
    output logic pin_tristate,
    output logic parport_tristate,
    output logic pin_drive_low,
    output logic pin_drive_high,
    output logic traffic_enable,
    output logic line_if_reset,
    output logic device_clearing,
    output logic [port_ctrl_pkg::NUM_FUNC*port_ctrl_pkg::NUM_MAP_BYTES*8-1:0] chan_map_bits
);
    import port_ctrl_pkg::*;

    localparam int LI_CNT_W = $clog2(LI_RECOVER_CYCLES + 1);
    localparam int BYTE_W = $clog2(NUM_MAP_BYTES);

    chan_map_if #(.NUM_FUNC(NUM_FUNC), .NUM_BYTES(NUM_MAP_BYTES)) map_bus();

    // Write channel holding registers
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;

    // Control and status state
    logic clearing;
    logic e1_r;
    pin_test_t test_r;
    logic [7:0] ptr_r;
    logic [7:0] line_if_control_two_r;
    logic [LI_CNT_W-1:0] li_cnt_r;
    logic [LI_CNT_W-1:0] li_cnt_nxt;
    logic traffic_r;
    logic soft_req;

    // Clear sequencer shared by every reset source
    reset_seq #(
        .CLEAR_CYCLES(CLEAR_CYCLES)
    ) u_reset_seq (
        .core_clk(core_clk),
        .reset(reset),
        .hw_reset_pin(hw_reset_pin),
        .soft_req(soft_req),
        .clearing(clearing)
    );

    // Channel map store
    chan_map_store #(
        .NUM_FUNC(NUM_FUNC),
        .NUM_BYTES(NUM_MAP_BYTES)
    ) u_chan_map_store (
        .core_clk(core_clk),
        .reset(reset),
        .bus(map_bus)
    );

    // Write decode: a write happens once address and data are both held
    wire do_write = !awready && !wready && !bvalid;
    wire [IDX_W-1:0] wr_idx = awaddr_q[ADDR_W-1:2];
    wire wr_aligned = (awaddr_q[1:0] == 2'b00);
    wire wr_hit = wr_aligned && reg_mapped(wr_idx);
    wire wr_commit = do_write && wr_hit && wstrb_q[0] && !clearing;
    wire [7:0] wr_byte = wdata_q[7:0];
    wire wr_master = wr_commit && (wr_idx == IDX_MASTER_MODE);
    wire wr_ptr = wr_commit && (wr_idx == IDX_FUNC_PTR);
    wire wr_chmap = wr_commit && (wr_idx >= IDX_CHMAP_LOW) && (wr_idx <= IDX_CHMAP_HIGH);
    wire wr_line_if_control_two = wr_commit && (wr_idx == IDX_LINE_IF_CTRL2);

    // Soft reset starts on a written one while no clear is running
    assign soft_req = wr_master && wr_byte[MM_SOFT_RESET_BIT] && !clearing;
    // Line interface reset starts only on a 0-to-1 change of its bit
    wire li_start = wr_line_if_control_two && wr_byte[LINE_IF_CONTROL_TWO_LINE_IF_RESET_BIT] && !line_if_control_two_r[LINE_IF_CONTROL_TWO_LINE_IF_RESET_BIT];

    // Map store writes; the pointer picks every function that takes the byte
    assign map_bus.clear = clearing;
    assign map_bus.wr_en = wr_chmap;
    assign map_bus.func_sel = ptr_r;
    assign map_bus.wr_byte = BYTE_W'(wr_idx - IDX_CHMAP_LOW);
    assign map_bus.wr_data = wr_byte;

    // Read decode
    wire [IDX_W-1:0] rd_idx = araddr[ADDR_W-1:2];
    wire rd_aligned = (araddr[1:0] == 2'b00);
    wire rd_hit = rd_aligned && reg_mapped(rd_idx);
    wire rd_is_chmap = (rd_idx >= IDX_CHMAP_LOW) && (rd_idx <= IDX_CHMAP_HIGH);
    assign map_bus.rd_byte = BYTE_W'(rd_idx - IDX_CHMAP_LOW);

    // Soft reset bit reads one until the clear it started is over
    wire [7:0] master_view = {4'h0, test_r, e1_r, clearing};
    wire [7:0] status_view = {5'h00, traffic_r, line_if_reset, clearing};
    wire [7:0] rd_byte =
        !rd_hit ? REG_RST :
        (rd_idx == IDX_MASTER_MODE) ? master_view :
        (rd_idx == IDX_FUNC_PTR) ? ptr_r :
        rd_is_chmap ? map_bus.rd_data :
        (rd_idx == IDX_LINE_IF_CTRL2) ? line_if_control_two_r :
        status_view;

    // Write address channel: one address held until its response is taken
    always_ff @(posedge core_clk) begin
        if (reset) begin
            awready <= 1'b1;
            awaddr_q <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            awaddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge core_clk) begin
        if (reset) begin
            wready <= 1'b1;
            wdata_q <= WORD_ZERO;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge core_clk) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel: data captured at the address handshake, answered next edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= WORD_ZERO;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Master mode fields; upper bits are not stored and read back as zero
    always_ff @(posedge core_clk) begin
        if (reset || clearing) begin
            e1_r <= 1'b0;
            test_r <= PIN_NORMAL;
        end else if (wr_master) begin
            e1_r <= wr_byte[MM_STANDARD_BIT];
            test_r <= pin_test_t'(wr_byte[MM_TEST_HI_BIT:MM_TEST_LO_BIT]);
        end
    end

    // Function pointer register
    always_ff @(posedge core_clk) begin
        if (reset || clearing) begin
            ptr_r <= REG_RST;
        end else if (wr_ptr) begin
            ptr_r <= wr_byte;
        end
    end

    // Line interface control two; only the reset bit acts inside this block
    always_ff @(posedge core_clk) begin
        if (reset || clearing) begin
            line_if_control_two_r <= REG_RST;
        end else if (wr_line_if_control_two) begin
            line_if_control_two_r <= wr_byte;
        end
    end

    // Recovery timer; a new toggle during recovery restarts the full wait
    assign li_cnt_nxt = li_start ? LI_CNT_W'(LI_RECOVER_CYCLES) :
                        (li_cnt_r != '0) ? li_cnt_r - LI_CNT_W'(1) : li_cnt_r;
    always_ff @(posedge core_clk) begin
        if (reset || clearing) begin
            li_cnt_r <= '0;
            line_if_reset <= 1'b0;
        end else begin
            li_cnt_r <= li_cnt_nxt;
            line_if_reset <= (li_cnt_nxt != '0);
        end
    end

    // Traffic stays off after any clear until the master mode is written again
    always_ff @(posedge core_clk) begin
        if (reset || clearing) begin
            traffic_r <= 1'b0;
        end else if (wr_master && !soft_req) begin
            traffic_r <= 1'b1;
        end
    end

    // Pin test outputs are registered so pads never see decode glitches
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_tristate <= 1'b0;
            parport_tristate <= 1'b0;
            pin_drive_low <= 1'b0;
            pin_drive_high <= 1'b0;
        end else begin
            pin_tristate <= (test_r == PIN_TRISTATE);
            parport_tristate <= (test_r == PIN_TRISTATE);
            pin_drive_low <= (test_r == PIN_DRIVE_LOW);
            pin_drive_high <= (test_r == PIN_DRIVE_HIGH);
        end
    end

    // Outputs mirrored from state flops
    always_ff @(posedge core_clk) begin
        if (reset) begin
            framer_e1_mode <= 1'b0;
            traffic_enable <= 1'b0;
            device_clearing <= 1'b1;
        end else begin
            framer_e1_mode <= e1_r;
            traffic_enable <= traffic_r;
            device_clearing <= clearing;
        end
    end

    // Channel maps leave straight from the store flops
    assign chan_map_bits = map_bus.map_flat;
endmodule

// ---- testbench/port_ctrl_chk.sv ----
// Checker for the port register bank, watching only its top ports.
// Assumes a bind from the bench top and one core clock domain.
`timescale 1ns/100ps
module port_ctrl_chk #(
    parameter int LI_RECOVER_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hw_reset_pin,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic framer_e1_mode,
    input wire logic pin_tristate,
    input wire logic parport_tristate,
    input wire logic pin_drive_low,
    input wire logic pin_drive_high,
    input wire logic traffic_enable,
    input wire logic line_if_reset,
    input wire logic device_clearing
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    int run_r;
    // Length of the current line reset pulse; a restart would show as an overlong pulse
    always_ff @(posedge core_clk) begin
        run_r <= (reset || !line_if_reset) ? 0 : run_r + 1;
    end
    a_release_clears: assert property ($fell(reset) |-> device_clearing && !traffic_enable)
        else $error("no clear after reset release");
    a_pin_clears: assert property (hw_reset_pin |-> ##[1:3] device_clearing)
        else $error("reset pin did not clear");
    a_clear_stops_traffic: assert property (device_clearing |=> !traffic_enable)
        else $error("traffic on after clear");
    a_clear_zeroes_modes: assert property (device_clearing |=>
        !framer_e1_mode && !pin_tristate && !pin_drive_low && !pin_drive_high) else $error("mode kept over clear");
    a_clear_self_ends: assert property ($rose(device_clearing) && !hw_reset_pin |->
        device_clearing[*8] ##[1:4] !device_clearing) else $error("clear length wrong");
    a_tristate_all: assert property (pin_tristate |->
        parport_tristate && !pin_drive_low && !pin_drive_high) else $error("tristate mode mixed");
    a_drive_keeps_port: assert property (pin_drive_low || pin_drive_high |->
        !parport_tristate && !(pin_drive_low && pin_drive_high)) else $error("drive mode mixed");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write not answered");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read not answered");
    a_line_reset_len: assert property ($fell(line_if_reset) |-> run_r == LI_RECOVER_CYCLES)
        else $error("line reset length wrong");
endmodule

// ---- testbench/host_bus_model.sv ----
// Host processor model: AXI4-Lite master for the port register bank.
// Assumes the same core clock; signals change only just after a rising edge.
`timescale 1ns/100ps
module host_bus_model (
    input wire logic core_clk,
    output logic [9:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [9:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    int hung = 0;
    // Idle bus at time zero
    initial begin
        {awaddr, araddr, wdata} = 52'h0_0000_0000_0000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        wstrb = 4'hf;
    end
    // One register write; released lines show the inverse so stale data never passes
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic aw;
        logic wd;
        int n;
        aw = 1'b1;
        wd = 1'b1;
        @(posedge core_clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, d};
        {awvalid, wvalid, bready} <= 3'h7;
        // First pass is forced: the raised bready has not settled in this step
        for (n = 0; n < 50 && (n == 0 || bready); n++) begin
            @(posedge core_clk);
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wd && wready) begin
                wd = 1'b0;
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (bvalid) bready <= 1'b0;
        end
        if (n == 50) hung++;
    endtask
    // One register read; rready stays up until the answer is sampled
    task automatic rd(input logic [7:0] idx);
        int n;
        @(posedge core_clk);
        araddr <= {idx, 2'b00};
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 50 && (n == 0 || rready); n++) begin
            @(posedge core_clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (rvalid) rready <= 1'b0;
        end
        if (n == 50) hung++;
    endtask
endmodule

// ---- testbench/tb_master_mode_and_per_channel_regs.sv ----
// Self-checking bench for the port register bank: bus, pin modes, channel maps, clears.
// Assumes the host model drives the bus and the checker is bound to the top module.
`timescale 1ns/100ps
module tb_master_mode_and_per_channel_regs;
    import port_ctrl_pkg::*;
    localparam int LI = 20;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hw_reset_pin = 1'b0;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic framer_e1_mode, pin_tristate, parport_tristate, pin_drive_low, pin_drive_high;
    logic traffic_enable, line_if_reset, device_clearing;
    logic [255:0] chan_map_bits;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] v, ptr;
    logic [7:0] map[4];
    int fails = 0;
    int checked = 0;
    int hi_run = 0;
    int last_run = 0;
    int i, f, b;

    port_ctrl_regs #(.LI_RECOVER_CYCLES(LI), .CLEAR_CYCLES(8)) i_port_ctrl_regs (
        .core_clk, .reset, .hw_reset_pin, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .framer_e1_mode, .pin_tristate, .parport_tristate, .pin_drive_low, .pin_drive_high,
        .traffic_enable, .line_if_reset, .device_clearing, .chan_map_bits);
    host_bus_model i_host_bus_model (.core_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready);

    always #10 core_clk = ~core_clk;

    task automatic close_out();
        fails = fails + i_host_bus_model.hung;
        $display("Counts: %0d compared, %0d mismatched", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Note the expected answer, then let the host model run the transfer
    task automatic w(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
        bq.push_back(resp);
        i_host_bus_model.wr(idx, d);
        if (i_host_bus_model.hung > 0) close_out();
    endtask
    task automatic r(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
        rq.push_back({resp, 24'h00_0000, d});
        i_host_bus_model.rd(idx);
        if (i_host_bus_model.hung > 0) close_out();
    endtask
    task automatic pins(input logic [5:0] e);
        chk("pins", 34'(e), 34'({traffic_enable, framer_e1_mode, pin_tristate, parport_tristate,
            pin_drive_low, pin_drive_high}));
    endtask
    task automatic wait_clear();
        for (i = 0; i < 60 && device_clearing !== 1'b0; i++) @(posedge core_clk);
        if (i == 60) begin
            fails++;
            close_out();
        end
    endtask

    // Answer monitor: oldest note against each handshake
    always @(posedge core_clk) begin
        if (rvalid && rready && rq.size() > 0) chk("read", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready && bq.size() > 0) chk("bresp", 34'(bq.pop_front()), 34'(bresp));
    end
    // Length of each line reset pulse
    always @(posedge core_clk) begin
        if (line_if_reset === 1'b1) hi_run <= hi_run + 1;
        else if (hi_run != 0) begin
            last_run <= hi_run;
            hi_run <= 0;
        end
    end

    initial begin
        void'($urandom(32'hc90555ca));
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        wait_clear();
        r(IDX_MASTER_MODE, 8'h00, RESP_OKAY);
        r(IDX_FUNC_PTR, 8'h00, RESP_OKAY);
        pins(6'h00);
        r(8'h10, 8'h00, RESP_SLVERR);
        w(8'h10, 8'h00, RESP_SLVERR);
        r(IDX_BLOCK_STATUS, 8'h00, RESP_OKAY);
        $display("Test reset values done");
        // Every standard and test mode pair; upper bits always zero
        for (f = 0; f < 8; f++) begin
            v = {4'h0, f[2:0], 1'b0};
            w(IDX_MASTER_MODE, v, RESP_OKAY);
            @(posedge core_clk);
            pins({1'b1, f[0], f[2:1] == 2'b01, f[2:1] == 2'b01, f[2:1] == 2'b10, f[2:1] == 2'b11});
            r(IDX_MASTER_MODE, v, RESP_OKAY);
        end
        $display("Test modes done");
        // Several functions mapped at once, read back one at a time
        ptr = 8'($urandom()) | 8'h18;
        w(IDX_FUNC_PTR, ptr, RESP_OKAY);
        for (b = 0; b < 4; b++) begin
            map[b] = 8'($urandom());
            w(IDX_CHMAP_LOW + 8'(b), map[b], RESP_OKAY);
        end
        for (f = 0; f < 8; f++) begin
            w(IDX_FUNC_PTR, 8'h01 << f, RESP_OKAY);
            for (b = 0; b < 4; b++) begin
                v = ptr[f] ? map[b] : 8'h00;
                chk("map bits", 34'(v), 34'(chan_map_bits[(f*4+b)*8 +: 8]));
                r(IDX_CHMAP_LOW + 8'(b), v, RESP_OKAY);
            end
        end
        $display("Test channel maps done");
        // Soft reset from E1 mode: busy while clearing, then all zero
        w(IDX_MASTER_MODE, 8'h03, RESP_OKAY);
        r(IDX_MASTER_MODE, 8'h01, RESP_OKAY);
        wait_clear();
        r(IDX_MASTER_MODE, 8'h00, RESP_OKAY);
        r(IDX_CHMAP_LOW, 8'h00, RESP_OKAY);
        chk("maps cleared", 34'h0, 34'(|chan_map_bits));
        pins(6'h00);
        $display("Test soft reset done");
        // Reset pin after reprogramming the standard first
        w(IDX_MASTER_MODE, 8'h02, RESP_OKAY);
        hw_reset_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        hw_reset_pin <= 1'b0;
        @(posedge core_clk);
        wait_clear();
        r(IDX_MASTER_MODE, 8'h00, RESP_OKAY);
        pins(6'h00);
        $display("Test reset pin done");
        // Line interface reset is the host's own write; busy shows in status, then the pulse length is checked
        w(IDX_LINE_IF_CTRL2, 8'h40, RESP_OKAY);
        r(IDX_BLOCK_STATUS, 8'h02, RESP_OKAY);
        for (i = 0; i < 100 && (line_if_reset !== 1'b0 || last_run == 0); i++) @(posedge core_clk);
        @(posedge core_clk);
        chk("line reset", 34'(LI), 34'(last_run));
        $display("Test line reset done");
        close_out();
    end
endmodule

bind port_ctrl_regs port_ctrl_chk #(.LI_RECOVER_CYCLES(LI_RECOVER_CYCLES)) i_port_ctrl_chk (
    .core_clk, .reset, .hw_reset_pin, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
    .arready, .rvalid, .framer_e1_mode, .pin_tristate, .parport_tristate, .pin_drive_low,
    .pin_drive_high, .traffic_enable, .line_if_reset, .device_clearing);
